// ### pafs_analog_dec.sv
// analog pin configuration and conversion channel decode
`timescale 1ns/1ns
`default_nettype none
module pafs_analog_dec
	import pafs_pkg::*;
(
	// settings
	input  wire logic [3:0]          cfg_n,
	input  wire logic [2:0]          chan,
	input  wire logic [ANA_PINS-1:0] dir,
	// decode
	output logic [ANA_PINS-1:0]      analog_mask,
	output logic [ANA_PINS-1:0]      convert_sel,
	output logic                     chan_ok
);
	logic [3:0] n_eff;

	// lowest n pins digital; prohibited codes above 8 clamp to all digital
	always_comb begin
		n_eff = (cfg_n > 4'h8) ? 4'h8 : cfg_n;
		for (int i = 0; i < ANA_PINS; i++) begin
			analog_mask[i] = !(4'(i) < n_eff);
			convert_sel[i] = analog_mask[i] && dir[i] && (chan == 3'(i));
		end
		// a named pin that is digital or an output does not convert
		chan_ok = |convert_sel;
	end
endmodule // pafs_analog_dec
`default_nettype wire

// ### pafs_far.sv
// far-side model: external pin levels and peripheral outputs
`timescale 1ns/1ns
`default_nettype none
module pafs_far
	import pafs_pkg::*;
(
	// device pins
	input  wire pafs_port_t pin_out,
	input  wire pafs_port_t pin_oe_n,
	output wire pafs_port_t pin_in,
	// bench settings
	input  wire pafs_port_t ext_lvl,
	input  wire pafs_port_t per_val,
	input  wire pafs_port_t per_own,
	// peripheral outputs
	output wire pafs_port_t alt_out,
	output wire pafs_port_t alt_out_sel
);
	// wire level: device drive where enabled, else the outside source (clock inputs too)
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
	assign alt_out = per_val;
	assign alt_out_sel = per_own;
endmodule // pafs_far
`default_nettype wire

// ### pafs_pin_cell.sv
// one port pin: drive, enable, alternate input and port read value
`timescale 1ns/1ns
`default_nettype none
module pafs_pin_cell
	import pafs_pkg::*;
(
	// configuration and synchronised pin level
	input  wire pafs_pin_cfg_s cfg,
	input  wire logic          pin_lvl,
	// results
	output logic               drive_out,
	output logic               drive_en,
	output logic               alt_in,
	output logic               read_val
);
	logic own_pin;

	// pin stays a port pin unless analog or oscillator has it
	always_comb begin
		own_pin  = !cfg.analog && !cfg.clk_pin;
		drive_en = own_pin && !cfg.dir;
		// latch 0 ors the peripheral output in, latch 1 ands it
		if (cfg.alt_sel) begin
			drive_out = cfg.lat ? (cfg.lat & cfg.alt_out) : (cfg.lat | cfg.alt_out);
		end else begin
			drive_out = cfg.lat;
		end
		alt_in   = (own_pin && cfg.dir) ? pin_lvl : 1'b0;
		// read never writes the latch
		if (!own_pin) begin
			read_val = 1'b0;
		end else begin
			read_val = cfg.dir ? pin_lvl : cfg.lat;
		end
	end
endmodule // pafs_pin_cell
`default_nettype wire

// ### pafs_pkg.sv
// shared constants, field layouts and carrier types of the port alternate function select
package pafs_pkg;

	// ------------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------------
	localparam int NPORT      = 4;
	localparam int PORT_W     = 8;
	localparam int PORT_ANA   = 2;    // analog-capable port index
	localparam int PORT_CLK   = 3;    // port holding the four clock-capable pins
	localparam int ANA_PINS   = 8;
	localparam int ADDR_W     = 8;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_LATCH  = 8'h00;  // port p latch at OFS_LATCH + 4p
	localparam logic [ADDR_W-1:0] OFS_DIR    = 8'h20;  // port p direction at OFS_DIR + 4p
	localparam logic [ADDR_W-1:0] OFS_ANA_CFG  = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_CHAN_SEL = 8'h44;
	localparam logic [ADDR_W-1:0] OFS_OSC    = 8'h48;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_DIR   = 8'hFF;
	localparam logic [3:0] RST_ANA_CFG  = 4'h0;
	localparam logic [2:0] RST_CHAN_SEL = 3'h0;
	localparam logic [7:0] RST_OSC   = 8'h00;

	// ------------------------------------------------------------------
	// oscillator mode field positions and clock pin bit positions
	// ------------------------------------------------------------------
	localparam int OSC_EXT_MAIN = 7;
	localparam int OSC_SEL_MAIN = 6;
	localparam int OSC_EXT_SUB  = 5;
	localparam int OSC_SEL_SUB  = 4;
	localparam int OSC_GAIN     = 0;
	localparam logic [7:0] OSC_MASK = 8'hF1;
	localparam int CLK_X1  = 1;
	localparam int CLK_X2  = 2;
	localparam int CLK_XT1 = 3;
	localparam int CLK_XT2 = 4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// per-pin configuration carried into a pin cell
	typedef struct packed {
		logic dir;      // 1 input, 0 output
		logic lat;
		logic alt_sel;  // a peripheral output owns the pin
		logic alt_out;
		logic analog;   // pin held as analog input
		logic clk_pin;  // pin taken by the oscillator
	} pafs_pin_cfg_s;

	typedef logic [NPORT-1:0][PORT_W-1:0] pafs_port_t;

endpackage : pafs_pkg

// ### pafs_props.sv
// concurrent checks on the ports of the port alternate function select
`timescale 1ns/1ns
`default_nettype none
module pafs_props
	import pafs_pkg::*;
(
	// clock and reset
	input wire logic          aclk,
	input wire logic          aresetn,
	// bus handshakes
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	// pins, converter and oscillator
	input wire pafs_port_t    pin_oe_n,
	input wire pafs_port_t    alt_in,
	input wire logic [7:0]    conversion_sel,
	input wire logic          conversion_chan_ok,
	input wire logic          main_resonator_en,
	input wire logic          sub_resonator_en,
	input wire logic          osc_high_gain
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// -----------
	// bus timing
	// -----------
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write answer not two edges after acceptance");
	a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read answer not one edge after acceptance");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped before taken");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped before taken");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open while answer pending");
	// -----------
	// pin routing
	// -----------
	// an alternate input sees only pins the device does not drive
	a_in_route: assert property ((alt_in & ~pin_oe_n) == '0)
		else $error("alternate input fed from output pin");
	a_main_pins: assert property (main_resonator_en |-> &pin_oe_n[PORT_CLK][2:1])
		else $error("main resonator pins still driven");
	a_sub_pins: assert property (sub_resonator_en |-> &pin_oe_n[PORT_CLK][4:3])
		else $error("sub resonator pins still driven");
	a_conv_one: assert property (conversion_sel != '0 |-> $onehot(conversion_sel)
		&& conversion_chan_ok && (conversion_sel & ~pin_oe_n[PORT_ANA]) == '0)
		else $error("conversion select not one analog input");
	// reset itself is the cause here, so this one is never disabled
	a_osc_reset: assert property (@(posedge aclk) disable iff (1'b0) !aresetn
		|=> !main_resonator_en && !sub_resonator_en && !osc_high_gain)
		else $error("oscillator outputs live after reset");
endmodule // pafs_props
bind pafs_top pafs_props pafs_props_inst (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .pin_oe_n, .alt_in, .conversion_sel, .conversion_chan_ok,
	.main_resonator_en, .sub_resonator_en, .osc_high_gain
);
`default_nettype wire

// ### pafs_top.sv
// port alternate function select with its AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pafs_top
	import pafs_pkg::*;
(
	// clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	// axi4-lite write response
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	// axi4-lite read data
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// external pins
	input  wire pafs_port_t          pin_in,
	output pafs_port_t               pin_out,
	output pafs_port_t               pin_oe_n,
	// peripheral side
	input  wire pafs_port_t          alt_out,
	input  wire pafs_port_t          alt_out_sel,
	output pafs_port_t               alt_in,
	// analog converter side
	output logic [ANA_PINS-1:0]      conversion_sel,
	output logic                     conversion_chan_ok,
	// oscillator side
	output logic                     main_resonator_en,
	output logic                     main_external_clock_in,
	output logic                     sub_resonator_en,
	output logic                     sub_external_clock_in,
	output logic                     osc_high_gain
);
	// ------------------------------------------------------------------
	// register state
	// ------------------------------------------------------------------
	pafs_port_t  latch_r, latch_nxt;
	pafs_port_t  dir_r, dir_nxt;
	logic [3:0]  analog_pin_config_r, analog_pin_config_nxt;
	logic [2:0]  conversion_channel_select_r, conversion_channel_select_nxt;
	logic [7:0]  oscillator_mode_select_r, oscillator_mode_select_nxt;

	// bus state
	logic              aw_got_r, aw_got_nxt;
	logic              w_got_r, w_got_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [7:0]        wbyte_r, wbyte_nxt;
	logic              wlane_r, wlane_nxt;
	logic              bvalid_r, bvalid_nxt;
	logic              awready_r, awready_nxt;
	logic              wready_r, wready_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic              rvalid_r, rvalid_nxt;
	logic              arready_r, arready_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic [1:0]        rresp_r, rresp_nxt;

	// pin side
	pafs_port_t  pin_meta_r, pin_sync_r;
	pafs_port_t  cell_out, cell_en, cell_alt, cell_read;
	pafs_port_t  pin_out_r, pin_oe_n_r, alt_in_r;
	logic [ANA_PINS-1:0] ana_mask, conv_sel, conv_sel_r;
	logic        chan_ok, chan_ok_r;
	logic [7:0]  clk_mask;
	logic        main_res_r, main_ext_r, sub_res_r, sub_ext_r, gain_r;

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	// register slot of an address, or -1 when unmapped
	function automatic int reg_slot(input logic [ADDR_W-1:0] a);
		int s;
		s = -1;
		if (a[1:0] == 2'h0) begin
			if (a < OFS_DIR) begin
				if (int'(a[ADDR_W-1:2]) < NPORT) s = int'(a[ADDR_W-1:2]);
			end else if (a < OFS_ANA_CFG) begin
				if (int'(a[ADDR_W-1:2]) - 8 < NPORT) s = NPORT + int'(a[ADDR_W-1:2]) - 8;
			end else if (a == OFS_ANA_CFG) begin
				s = 2 * NPORT;
			end else if (a == OFS_CHAN_SEL) begin
				s = 2 * NPORT + 1;
			end else if (a == OFS_OSC) begin
				s = 2 * NPORT + 2;
			end
		end
		return s;
	endfunction

	// ------------------------------------------------------------------
	// write channel and register next values
	// ------------------------------------------------------------------
	// address and data are taken in either order, response after both
	always_comb begin
		int s;
		s = -1;
		aw_got_nxt = aw_got_r;
		w_got_nxt  = w_got_r;
		awaddr_nxt = awaddr_r;
		wbyte_nxt  = wbyte_r;
		wlane_nxt  = wlane_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt  = bresp_r;
		latch_nxt  = latch_r;
		dir_nxt    = dir_r;
		analog_pin_config_nxt         = analog_pin_config_r;
		conversion_channel_select_nxt = conversion_channel_select_r;
		oscillator_mode_select_nxt    = oscillator_mode_select_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt = 1'b1;
			wbyte_nxt = s_axi_wdata[7:0];
			wlane_nxt = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_got_r && w_got_r && !bvalid_r) begin
			s          = reg_slot(awaddr_r);
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = (s < 0) ? RESP_SLVERR : RESP_OKAY;
			// only byte lane 0 carries register bits
			if (wlane_r && s >= 0) begin
				if (s < NPORT) begin
					latch_nxt[s] = wbyte_r;
				end else if (s < 2 * NPORT) begin
					dir_nxt[s - NPORT] = wbyte_r;
				end else if (s == 2 * NPORT) begin
					analog_pin_config_nxt = wbyte_r[3:0];
				end else if (s == 2 * NPORT + 1) begin
					conversion_channel_select_nxt = wbyte_r[2:0];
				end else begin
					oscillator_mode_select_nxt = wbyte_r & OSC_MASK;
				end
			end
		end
		// readies are registered so every bus output comes from a flop
		awready_nxt = !aw_got_nxt && !bvalid_nxt;
		wready_nxt  = !w_got_nxt && !bvalid_nxt;
	end

	// register the write side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= '0;
			wbyte_r  <= 8'h00;
			wlane_r  <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			for (int p = 0; p < NPORT; p++) begin
				latch_r[p] <= RST_LATCH;
				dir_r[p]   <= RST_DIR;
			end
			analog_pin_config_r         <= RST_ANA_CFG;
			conversion_channel_select_r <= RST_CHAN_SEL;
			oscillator_mode_select_r    <= RST_OSC;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r  <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wbyte_r  <= wbyte_nxt;
			wlane_r  <= wlane_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r  <= bresp_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			latch_r  <= latch_nxt;
			dir_r    <= dir_nxt;
			analog_pin_config_r         <= analog_pin_config_nxt;
			conversion_channel_select_r <= conversion_channel_select_nxt;
			oscillator_mode_select_r    <= oscillator_mode_select_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	// ------------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------------
	// a latch read returns the port value seen by software
	always_comb begin
		int s;
		s          = -1;
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s          = reg_slot(s_axi_araddr);
			rvalid_nxt = 1'b1;
			rresp_nxt  = (s < 0) ? RESP_SLVERR : RESP_OKAY;
			rdata_nxt  = 32'h0000_0000;
			if (s >= 0 && s < NPORT) begin
				rdata_nxt[7:0] = cell_read[s];
			end else if (s >= NPORT && s < 2 * NPORT) begin
				rdata_nxt[7:0] = dir_r[s - NPORT];
			end else if (s == 2 * NPORT) begin
				rdata_nxt[3:0] = analog_pin_config_r;
			end else if (s == 2 * NPORT + 1) begin
				rdata_nxt[2:0] = conversion_channel_select_r;
			end else if (s == 2 * NPORT + 2) begin
				rdata_nxt[7:0] = oscillator_mode_select_r;
			end
		end
		arready_nxt = !rvalid_nxt;
	end

	// register the read side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
			arready_r <= 1'b1;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
			arready_r <= arready_nxt;
		end
	end

	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// ------------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------------
	// pins are asynchronous; only the second stage is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ------------------------------------------------------------------
	// analog decode, clock pin ownership and pin cells
	// ------------------------------------------------------------------
	pafs_analog_dec pafs_analog_dec_inst (
		.cfg_n       (analog_pin_config_r),
		.chan        (conversion_channel_select_r),
		.dir         (dir_r[PORT_ANA]),
		.analog_mask (ana_mask),
		.convert_sel (conv_sel),
		.chan_ok     (chan_ok)
	);

	// oscillator mode alone decides, direction and latch are ignored
	always_comb begin
		clk_mask          = 8'h00;
		clk_mask[CLK_X1]  = oscillator_mode_select_r[OSC_SEL_MAIN]
			&& !oscillator_mode_select_r[OSC_EXT_MAIN];
		clk_mask[CLK_X2]  = oscillator_mode_select_r[OSC_SEL_MAIN];
		clk_mask[CLK_XT1] = oscillator_mode_select_r[OSC_SEL_SUB]
			&& !oscillator_mode_select_r[OSC_EXT_SUB];
		clk_mask[CLK_XT2] = oscillator_mode_select_r[OSC_SEL_SUB];
	end

	for (genvar p = 0; p < NPORT; p++) begin : g_port
		for (genvar b = 0; b < PORT_W; b++) begin : g_bit
			pafs_pin_cfg_s cfg;
			assign cfg.dir     = dir_r[p][b];
			assign cfg.lat     = latch_r[p][b];
			assign cfg.alt_sel = alt_out_sel[p][b];
			assign cfg.alt_out = alt_out[p][b];
			assign cfg.analog  = (p == PORT_ANA) ? ana_mask[b] : 1'b0;
			assign cfg.clk_pin = (p == PORT_CLK) ? clk_mask[b] : 1'b0;
			pafs_pin_cell pafs_pin_cell_inst (
				.cfg       (cfg),
				.pin_lvl   (pin_sync_r[p][b]),
				.drive_out (cell_out[p][b]),
				.drive_en  (cell_en[p][b]),
				.alt_in    (cell_alt[p][b]),
				.read_val  (cell_read[p][b])
			);
		end
	end

	// ------------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------------
	// one cycle of latency buys glitch-free pin and peripheral outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_r  <= '0;
			pin_oe_n_r <= '1;
			alt_in_r   <= '0;
			conv_sel_r <= '0;
			chan_ok_r  <= 1'b0;
			main_res_r <= 1'b0;
			main_ext_r <= 1'b0;
			sub_res_r  <= 1'b0;
			sub_ext_r  <= 1'b0;
			gain_r     <= 1'b0;
		end else begin
			pin_out_r  <= cell_out;
			pin_oe_n_r <= ~cell_en;
			alt_in_r   <= cell_alt;
			conv_sel_r <= conv_sel;
			chan_ok_r  <= chan_ok;
			main_res_r <= clk_mask[CLK_X1];
			main_ext_r <= clk_mask[CLK_X2] && !clk_mask[CLK_X1]
				&& pin_sync_r[PORT_CLK][CLK_X2];
			sub_res_r  <= clk_mask[CLK_XT1];
			sub_ext_r  <= clk_mask[CLK_XT2] && !clk_mask[CLK_XT1]
				&& pin_sync_r[PORT_CLK][CLK_XT2];
			gain_r     <= oscillator_mode_select_r[OSC_GAIN];
		end
	end

	assign pin_out                = pin_out_r;
	assign pin_oe_n               = pin_oe_n_r;
	assign alt_in                 = alt_in_r;
	assign conversion_sel         = conv_sel_r;
	assign conversion_chan_ok     = chan_ok_r;
	assign main_resonator_en      = main_res_r;
	assign main_external_clock_in = main_ext_r;
	assign sub_resonator_en       = sub_res_r;
	assign sub_external_clock_in  = sub_ext_r;
	assign osc_high_gain          = gain_r;

endmodule // pafs_top
`default_nettype wire

// ### port_alternate_function_select_test.sv
// self-checking bench of the port alternate function select
`timescale 1ns/1ns
`default_nettype none
module port_alternate_function_select_test;
	import pafs_pkg::*;
	// -----------
	// signals and model state
	// -----------
	logic              aclk, aresetn;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, d;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready;
	pafs_port_t        pin_in, pin_out, pin_oe_n, alt_out, alt_out_sel, alt_in;
	pafs_port_t        ext_lvl, per_val, per_own, own_m;
	logic [7:0]        conversion_sel, osc_m, rd_m;
	logic              conversion_chan_ok, main_resonator_en, main_external_clock_in;
	logic              sub_resonator_en, sub_external_clock_in, osc_high_gain;
	logic [7:0]        lat_m [4];
	logic [7:0]        dir_m [4];
	int                failures, checks, n_m, ads_m, i, p;

	pafs_top pafs_top_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n, .alt_out, .alt_out_sel,
		.alt_in, .conversion_sel, .conversion_chan_ok, .main_resonator_en,
		.main_external_clock_in, .sub_resonator_en, .sub_external_clock_in, .osc_high_gain
	);
	pafs_far pafs_far_inst (
		.pin_out, .pin_oe_n, .pin_in, .ext_lvl, .per_val, .per_own, .alt_out, .alt_out_sel
	);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// -----------
	// checking and bus tasks
	// -----------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ready raised a cycle late so the slave must hold its answer
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				break;
			if (n == 2)
				s_axi_bready <= 1'b1;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50)
			chk("write wait", 0, 1);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				break;
			if (n == 1)
				s_axi_rready <= 1'b1;
		end
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50)
			chk("read wait", 0, 1);
	endtask
	task automatic wr_ok(input logic [7:0] a, input logic [7:0] v);
		axi_wr(a, {24'h0, v}, r);
		chk("bresp", r, RESP_OKAY);
	endtask
	// expected oe_n, drive, alternate input and read bit of one pin
	function automatic logic [3:0] pin_exp(int pt, int b);
		logic l, v, own;
		l = lat_m[pt][b];
		v = ext_lvl[pt][b];
		own = (b == CLK_X1 && osc_m[6] && !osc_m[7]) || (b == CLK_X2 && osc_m[6]) ||
			(b == CLK_XT1 && osc_m[4] && !osc_m[5]) || (b == CLK_XT2 && osc_m[4]);
		if ((pt == PORT_ANA && b >= n_m) || (pt == PORT_CLK && own))
			return 4'b1000;
		if (dir_m[pt][b])
			return {2'b10, v, v};
		v = per_val[pt][b];
		return {1'b0, per_own[pt][b] ? (l ? l & v : l | v) : l, 1'b0, l};
	endfunction
	task automatic compare_all;
		logic [3:0] e;
		logic ok;
		int b;
		repeat (8) @(posedge aclk); // two sync edges and an output register, with margin
		for (p = 0; p < NPORT; p++) begin
			for (b = 0; b < PORT_W; b++) begin
				e = pin_exp(p, b);
				rd_m[b] = e[0];
				chk("pin_oe_n", pin_oe_n[p][b], e[3]);
				if (!e[3])
					chk("pin_out", pin_out[p][b], e[2]);
				chk("alt_in", alt_in[p][b], e[1]);
			end
			axi_rd(OFS_LATCH + 8'(4 * p), d, r);
			chk("port read", d, {24'h0, rd_m});
		end
		ok = ads_m >= n_m && dir_m[PORT_ANA][ads_m];
		chk("conversion_sel", conversion_sel, ok ? 8'h01 << ads_m : 8'h00);
		chk("chan_ok", conversion_chan_ok, ok);
		chk("main_res", main_resonator_en, osc_m[6] & !osc_m[7]);
		chk("main_ext", main_external_clock_in, &osc_m[7:6] & ext_lvl[PORT_CLK][CLK_X2]);
		chk("sub_res", sub_resonator_en, osc_m[4] & !osc_m[5]);
		chk("sub_ext", sub_external_clock_in, &osc_m[5:4] & ext_lvl[PORT_CLK][CLK_XT2]);
		chk("gain", osc_high_gain, osc_m[0]);
	endtask
	// watchdog: the run needs under two thousand cycles
	initial begin
		#400000;
		failures++;
		give_verdict;
	end
	// -----------
	// main sequence
	// -----------
	initial begin
		failures = 0;
		checks = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		per_val = '0;
		per_own = '0;
		void'($urandom(32'hD63A));
		ext_lvl = 32'($urandom);
		for (p = 0; p < NPORT; p++) begin
			lat_m[p] = RST_LATCH;
			dir_m[p] = RST_DIR;
		end
		osc_m = RST_OSC;
		n_m = 0;
		ads_m = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset values, then refused addresses
		for (p = 0; p < NPORT; p++) begin
			axi_rd(OFS_DIR + 8'(4 * p), d, r);
			chk("dir reset", d, {24'h0, RST_DIR});
		end
		axi_rd(OFS_ANA_CFG, d, r);
		chk("analog cfg reset", d, 32'h0);
		axi_rd(OFS_OSC, d, r);
		chk("osc reset", d, 32'h0);
		axi_rd(8'hFC, d, r);
		chk("unmapped rresp", r, RESP_SLVERR);
		axi_wr(8'hFC, 32'hFF, r);
		chk("unmapped bresp", r, RESP_SLVERR);
		compare_all;
		// random settings kept within what software may legally do
		for (i = 0; i < 16; i++) begin
			n_m = $urandom % 8;
			ads_m = n_m + $urandom % (8 - n_m);
			// a peripheral output only ever owns a pin set as output
			for (p = 0; p < NPORT; p++) begin
				lat_m[p] = 8'($urandom);
				dir_m[p] = 8'($urandom);
				if (p == PORT_ANA)
					dir_m[p] |= 8'hFF << n_m;
				own_m[p] = 8'($urandom) & ~dir_m[p];
			end
			osc_m = 8'($urandom);
			ext_lvl <= 32'($urandom);
			per_val <= 32'($urandom);
			per_own <= own_m;
			for (p = 0; p < NPORT; p++) begin
				wr_ok(OFS_LATCH + 8'(4 * p), lat_m[p]);
				wr_ok(OFS_DIR + 8'(4 * p), dir_m[p]);
			end
			wr_ok(OFS_ANA_CFG, 8'(n_m));
			wr_ok(OFS_CHAN_SEL, 8'(ads_m));
			wr_ok(OFS_OSC, osc_m);
			osc_m &= OSC_MASK; // unused mode bits read back as zero
			axi_rd(OFS_OSC, d, r);
			chk("osc read", d, {24'h0, osc_m});
			compare_all;
		end
		give_verdict;
	end
endmodule // port_alternate_function_select_test
`default_nettype wire
